/* File: test/sbrg_checker.sv */
// sbrg_checker: port assertions for sbrg_top
// assumes i_ce held high; shadows registers from apb writes
`timescale 1ns/1ps
`default_nettype none
module sbrg_checker
    import sbrg_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire logic [7:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_RATE_TICK,
    input wire logic [1:0] O_MULT_SEL,
    input wire logic O_SYNC_MODE
);
    // ==================================================================
    // shadow state
    logic [7:0] lo, hi;
    logic [2:0] cfg;
    logic [16:0] cnt, due;
    logic ok, acc, wr, dw;
    logic [1:0] mx;
    assign acc = I_PSEL && I_PENABLE && I_CE;
    assign wr = acc && I_PWRITE && !O_PSLVERR;
    assign dw = wr && (I_PADDR == OFS_DIVISOR_LOW ||
        I_PADDR == OFS_DIVISOR_HIGH);
    assign due = (cfg[2] ? {1'h0, hi, lo} : {9'h0, lo}) + 17'h1;
    assign mx = {cfg[0] || (cfg[2] && cfg[1]), !cfg[0] && (cfg[2] ^ cfg[1])};
    // widening the divisor does not clear the timer, so period checks pause
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            lo <= 8'h00;
            hi <= 8'h00;
            cfg <= 3'h0;
            cnt <= 17'h0;
            ok <= 1'b1;
        end else begin
            cnt <= dw ? 17'h0 : (O_RATE_TICK ? 17'h1 : cnt + 17'h1);
            ok <= dw || (ok && !(wr && I_PADDR == OFS_BAUD_CONTROL));
            if (dw && I_PADDR == OFS_DIVISOR_LOW) lo <= I_PWDATA[7:0];
            if (dw && I_PADDR == OFS_DIVISOR_HIGH) hi <= I_PWDATA[7:0];
            if (wr && I_PADDR == OFS_BAUD_CONTROL) cfg[2] <= I_PWDATA[3];
            if (wr && I_PADDR == OFS_TRANSMIT_CTRL) cfg[1] <= I_PWDATA[2];
            if (wr && I_PADDR == OFS_TRANSMIT_CTRL) cfg[0] <= I_PWDATA[4];
        end
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    // ==================================================================
    // assertions
    chk_tick_period: assert property (
        O_RATE_TICK && ok |-> cnt == due)
        else $error("tick off its divisor period");
    chk_tick_due: assert property (ok && cnt == due |-> O_RATE_TICK)
        else $error("tick missing when due");
    chk_tick_pulse: assert property (
        O_RATE_TICK && ok && due != 17'h1 |=> !O_RATE_TICK)
        else $error("tick longer than one cycle");
    chk_mult_sel: assert property (
        $stable(cfg) && cfg == $past(cfg, 2) |-> O_MULT_SEL == mx)
        else $error("multiplier select wrong");
    chk_sync_out: assert property (
        $stable(cfg) && cfg == $past(cfg, 2) |-> O_SYNC_MODE == cfg[0])
        else $error("sync mode output wrong");
    chk_ready_high: assert property (acc |-> O_PREADY)
        else $error("pready low in access");
    chk_err_unmapped: assert property (
        acc && I_PADDR > 8'h10 |-> O_PSLVERR)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property (acc && I_PADDR == OFS_DIVISOR_HIGH |-> !O_PSLVERR)
        else $error("error on mapped address");
endmodule // sbrg_checker
bind sbrg_top sbrg_checker i_sbrg_checker (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
    .I_CE(I_CE), .I_PADDR(I_PADDR), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .O_RATE_TICK(O_RATE_TICK),
    .O_MULT_SEL(O_MULT_SEL), .O_SYNC_MODE(O_SYNC_MODE));
`default_nettype wire

/* File: test/tb.sv */
// tb: register and tick-rate tests for sbrg_top
// assumes a zero-wait apb slave and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sbrg_pkg::*;
    logic clk, rst, ce, psel, pen, pwr, idle, pready, perr, tick, smode, er;
    logic [7:0] paddr;
    logic [31:0] pwd, prd, rd;
    logic [1:0] msel, em;
    int n_fail, checked, k;
    sbrg_top i_sbrg_top (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce),
        .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready), .O_PSLVERR(perr),
        .I_RECEIVER_IDLE(idle), .O_RATE_TICK(tick), .O_MULT_SEL(msel),
        .O_SYNC_MODE(smode));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==================================================================
    // tasks
    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // edges from the divisor write to first tick, then tick to tick
    task automatic rate(input int n);
        for (int j = 0; j < 2; j++) begin
            k = 0;
            do begin
                @(posedge clk);
                #1;
                k++;
            end while (tick !== 1'b1 && k < 70000);
            cmp("tick spacing", n + 1, k);
        end
    endtask
    task automatic conclude();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        conclude();
    end
    // ==================================================================
    // tests
    initial begin
        {rst, ce, idle, psel, pen, pwr, paddr, pwd} = {3'h7, 43'h0};
        n_fail = 0;
        checked = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, OFS_BAUD_CONTROL, 32'h0);
        cmp("idle flag", 32'h40, rd);
        idle <= 1'b0;
        apb(1'b0, OFS_BAUD_CONTROL, 32'h0);
        cmp("busy flag", 32'h0, rd);
        apb(1'b0, 8'h14, 32'h0);
        cmp("unmapped err", 32'h1, {31'h0, er});
        apb(1'b1, OFS_DIVISOR_HIGH, 32'h5);
        apb(1'b0, OFS_DIVISOR_HIGH, 32'h0);
        cmp("divisor high", 32'h5, rd);
        apb(1'b1, OFS_DIVISOR_LOW, 32'h3);
        rate(3);
        apb(1'b1, OFS_BAUD_CONTROL, 32'h8);
        apb(1'b1, OFS_DIVISOR_LOW, 32'h3);
        rate(16'h0503);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, OFS_BAUD_CONTROL, {28'h0, i[0], 3'h0});
            apb(1'b1, OFS_TRANSMIT_CTRL,
                {27'h0, i[2], 1'b0, i[1], 2'h0});
            repeat (3) @(posedge clk);
            #1;
            em = {i[2] || (i[0] && i[1]), !i[2] && (i[0] ^ i[1])};
            cmp("mult", em, msel);
            cmp("sync", {31'h0, i[2]}, {31'h0, smode});
        end
        apb(1'b0, OFS_TRANSMIT_CTRL, 32'h0);
        cmp("transmit ctrl", 32'h14, rd);
        apb(1'b1, OFS_DIVISOR_LOW, 32'h2);
        rate(16'h0502);
        conclude();
    end
endmodule // tb
`default_nettype wire

/* File: verilog/sbrg_pkg.sv */
// sbrg_pkg: register map, field positions and reset values of the baud timer
// assumes a 32-bit apb slave, one register per aligned word
package sbrg_pkg;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_DIVISOR_LOW = 8'h00;
    localparam logic [7:0] OFS_DIVISOR_HIGH = 8'h04;
    localparam logic [7:0] OFS_BAUD_CONTROL = 8'h08;
    localparam logic [7:0] OFS_TRANSMIT_CTRL = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ==================================================================
    // field positions
    localparam int WIDE_DIVIDER_BIT = 3;
    localparam int RECEIVER_IDLE_BIT = 6;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int SYNC_MODE_BIT = 4;

    // ==================================================================
    // reset values
    localparam logic [7:0] DIVISOR_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // ==================================================================
    // multiplier selection handed downstream
    typedef enum logic [1:0] {
        SBRG_MULT_64 = 2'b00,
        SBRG_MULT_16 = 2'b01,
        SBRG_MULT_4 = 2'b10
    } sbrg_mult_t;

    typedef struct packed {
        logic wide_divider_select;
        logic high_speed_select;
        logic sync_mode;
    } sbrg_cfg_t;

endpackage

/* File: verilog/sbrg_top.sv */
// sbrg_top: serial baud timer with apb register access
// assumes the serial port's receiver supplies its idle level on this clock
// Overview of operation
// - after reset the timer counts with the low divisor byte only
// - wide divider select makes the timer use both divisor bytes
// - one timer tick serves both asynchronous and synchronous modes
// - timer runs continuously; period comes from the divisor pair when wide, low byte alone when narrow
// - async multiplier chosen jointly by high speed and wide divider bits
// - in synchronous mode the high speed bit is ignored
// - writing either divisor register clears the timer immediately
// - async, narrow, low speed: rate is clock over 64 times n+1
// - async, wide, low speed: rate is clock over 16 times n+1
// - synchronous: rate is clock over 4 times n+1
// - divisor is high byte above low byte, unsigned
// - receiver idle flag reads high while the receiver is idle
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module sbrg_top
    import sbrg_pkg::*;
#(
    parameter int DIV_WIDTH = 16
) (
    // clock, reset, enable
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_CE,
    // apb slave
    input wire logic [7:0] I_PADDR,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // receiver status in
    input wire logic I_RECEIVER_IDLE,
    // timer outputs
    output logic O_RATE_TICK,
    output logic [1:0] O_MULT_SEL,
    output logic O_SYNC_MODE
);

    // ==================================================================
    // parameter check
    if (DIV_WIDTH != 16) begin : g_bad_width
        $error("sbrg_top: DIV_WIDTH must be 16");
    end

    // control fields must sit inside the 8-bit register views
    if (WIDE_DIVIDER_BIT > 7 || RECEIVER_IDLE_BIT > 7 ||
        HIGH_SPEED_BIT > 7 || SYNC_MODE_BIT > 7) begin : g_bad_field
        $error("sbrg_top: control field outside the register");
    end

    // ==================================================================
    // register and timer state
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    sbrg_cfg_t cfg;
    logic [31:0] prdata;
    logic [15:0] timer;
    logic tick;
    logic [7:0] next_divisor_low;
    logic [7:0] next_divisor_high;
    sbrg_cfg_t next_cfg;
    logic [31:0] next_prdata;
    logic [15:0] next_timer;
    logic next_tick;
    logic [15:0] period;

    // ==================================================================
    // bus side signals
    logic access;
    logic wr;
    logic sel_low;
    logic sel_high;
    logic sel_baud;
    logic sel_xmit;
    logic sel_status;
    logic mapped;
    logic divisor_written;
    logic [7:0] baud_view;
    logic [7:0] xmit_view;
    logic [31:0] read_word;
    logic rx_idle;

    // ==================================================================
    // receiver idle level: same clock, no synchroniser needed
    assign rx_idle = I_RECEIVER_IDLE;

    // ==================================================================
    // apb qualifiers: a frozen block takes no access
    assign access = I_PSEL && I_PENABLE && I_CE;
    assign wr = access && I_PWRITE;

    // ==================================================================
    // address decode
    always_comb begin
        sel_low = 1'b0;
        sel_high = 1'b0;
        sel_baud = 1'b0;
        sel_xmit = 1'b0;
        sel_status = 1'b0;
        case (I_PADDR)
            OFS_DIVISOR_LOW: begin
                sel_low = 1'b1;
            end
            OFS_DIVISOR_HIGH: begin
                sel_high = 1'b1;
            end
            OFS_BAUD_CONTROL: begin
                sel_baud = 1'b1;
            end
            OFS_TRANSMIT_CTRL: begin
                sel_xmit = 1'b1;
            end
            OFS_STATUS: begin
                sel_status = 1'b1;
            end
            default: begin
                // unaligned or unused: nothing selected, error raised
                sel_low = 1'b0;
            end
        endcase
    end

    assign mapped = sel_low || sel_high || sel_baud || sel_xmit || sel_status;

    // ==================================================================
    // register writes; unmapped writes leave everything unchanged
    always_comb begin
        next_divisor_low = divisor_low;
        next_divisor_high = divisor_high;
        next_cfg = cfg;
        divisor_written = 1'b0;
        if (wr && sel_low) begin
            next_divisor_low = I_PWDATA[7:0];
            divisor_written = 1'b1;
        end
        if (wr && sel_high) begin
            next_divisor_high = I_PWDATA[7:0];
            divisor_written = 1'b1;
        end
        if (wr && sel_baud) begin
            next_cfg.wide_divider_select = I_PWDATA[WIDE_DIVIDER_BIT];
        end
        if (wr && sel_xmit) begin
            next_cfg.high_speed_select = I_PWDATA[HIGH_SPEED_BIT];
            next_cfg.sync_mode = I_PWDATA[SYNC_MODE_BIT];
        end
    end

    // ==================================================================
    // control register views, one bit slice each
    // unimplemented bits read as zero
    for (genvar b = 0; b < 8; b++) begin : g_view
        if (b == WIDE_DIVIDER_BIT) begin : g_wide
            assign baud_view[b] = cfg.wide_divider_select;
        end else if (b == RECEIVER_IDLE_BIT) begin : g_idle
            assign baud_view[b] = rx_idle;
        end else begin : g_zero_baud
            assign baud_view[b] = 1'b0;
        end
        if (b == HIGH_SPEED_BIT) begin : g_speed
            assign xmit_view[b] = cfg.high_speed_select;
        end else if (b == SYNC_MODE_BIT) begin : g_sync
            assign xmit_view[b] = cfg.sync_mode;
        end else begin : g_zero_xmit
            assign xmit_view[b] = 1'b0;
        end
    end

    // ==================================================================
    // read data; idle flag and timer are live, not stored
    always_comb begin
        read_word = 32'h00000000;
        if (sel_low) begin
            read_word[7:0] = divisor_low;
        end
        if (sel_high) begin
            read_word[7:0] = divisor_high;
        end
        if (sel_baud) begin
            read_word[7:0] = baud_view;
        end
        if (sel_xmit) begin
            read_word[7:0] = xmit_view;
        end
        if (sel_status) begin
            read_word[15:0] = timer;
        end
    end

    // hold the last word outside an access so the bus stays quiet
    always_comb begin
        next_prdata = prdata;
        if (access) begin
            next_prdata = read_word;
        end
    end

    // ==================================================================
    // baud timer

    always_comb begin
        // narrow mode ignores the high byte
        if (cfg.wide_divider_select) begin
            period = {divisor_high, divisor_low};
        end else begin
            period = {8'h00, divisor_low};
        end
        next_tick = 1'b0;
        if (divisor_written) begin
            next_timer = 16'h0000;
        end else if (timer >= period) begin
            // tick every period+1 clocks, free running
            next_timer = 16'h0000;
            next_tick = 1'b1;
        end else begin
            next_timer = timer + 16'h0001;
        end
    end

    // ==================================================================
    // multiplier select for the downstream prescaler
    logic [1:0] mult;
    logic [1:0] next_mult;

    always_comb begin
        if (cfg.sync_mode) begin
            next_mult = SBRG_MULT_4;
        end else begin
            case ({cfg.wide_divider_select, cfg.high_speed_select})
                2'b00: next_mult = SBRG_MULT_64;
                2'b10: next_mult = SBRG_MULT_16;
                2'b01: next_mult = SBRG_MULT_16;
                2'b11: next_mult = SBRG_MULT_4;
                default: next_mult = SBRG_MULT_64;
            endcase
        end
    end

    // ==================================================================
    // register file
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            divisor_low <= DIVISOR_RESET;
            divisor_high <= DIVISOR_RESET;
            cfg <= sbrg_cfg_t'(CONFIG_RESET[2:0]);
            prdata <= 32'h00000000;
        end else if (I_CE) begin
            divisor_low <= next_divisor_low;
            divisor_high <= next_divisor_high;
            cfg <= next_cfg;
            prdata <= next_prdata;
        end
    end

    // ==================================================================
    // timer state; the enable freezes the count mid period
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            timer <= 16'h0000;
            tick <= 1'b0;
        end else if (I_CE) begin
            timer <= next_timer;
            tick <= next_tick;
        end
    end

    // ==================================================================
    // multiplier state
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            mult <= SBRG_MULT_64;
        end else if (I_CE) begin
            mult <= next_mult;
        end
    end

    // zero wait states; read data from a flop updated at the access edge
    // means prdata is combinationally chosen below for same-cycle return
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
    assign O_PRDATA = (I_PSEL && I_PENABLE) ? next_prdata : prdata;
    assign O_RATE_TICK = tick;
    assign O_MULT_SEL = mult;
    assign O_SYNC_MODE = cfg.sync_mode;

endmodule // sbrg_top

`default_nettype wire
